// >>> common/wdg_pkg.sv
// constants and types for the programmable watchdog
`default_nettype none
package wdg_pkg;
  localparam logic [7:0] SERVICE_ADDR  = 8'hA6;
  localparam logic [7:0] CONTROL_ADDR  = 8'hA7;
  localparam logic [7:0] KEY_FIRST     = 8'h1E;
  localparam logic [7:0] KEY_SECOND    = 8'hE1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_NONE     = 8'h00;
  localparam int PS_LSB       = 5;
  localparam int PS_MSB       = 7;
  localparam int IDLE_BIT     = 4;
  localparam int OVF_BIT      = 1;
  localparam int RUN_BIT      = 0;
  localparam int PRE_W        = 7;
  localparam int TMR_W        = 14;
  localparam int PS_W         = 3;
  localparam logic [PRE_W-1:0] PRE_ONE  = 7'h01;
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
  localparam logic [TMR_W-1:0] TMR_ZERO = 14'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 14'h0001;
  localparam logic [PS_W-1:0]  PS_ZERO  = 3'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdg_sfr_req_t;

  typedef enum logic {WDG_KEY_IDLE, WDG_KEY_ARMED} wdg_key_state_t;
endpackage
`default_nettype wire

// >>> rtl/wdg_top.sv
// watchdog unit: key sequencer, prescaler, timer and control register
`timescale 1ns/1ps
`default_nettype none
module wdg_top (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  other_reset,
  input  wire logic                  idle_mode,
  input  wire logic                  power_down,
  input  wire wdg_pkg::wdg_sfr_req_t sfr_req,
  output var  logic [7:0]            sfr_rdata,
  output var  logic                  wd_reset_pulse
);
  wdg_pkg::wdg_key_state_t        key_q, key_d;
  logic [wdg_pkg::PS_W-1:0]       ps_q;
  logic                           idle_freeze_q;
  logic                           overflow_flag_q;
  logic                           running_status_q;
  logic [wdg_pkg::PRE_W-1:0]      pre_q;
  logic [wdg_pkg::TMR_W-1:0]      tmr_q;

  // tap mask: low ps bits of the prescaler must be all ones for a tick
  function automatic logic [wdg_pkg::PRE_W-1:0] tap_mask(
    input logic [wdg_pkg::PS_W-1:0] ps);
    tap_mask = (wdg_pkg::PRE_ONE << ps) - wdg_pkg::PRE_ONE;
  endfunction

  wire wr_service = sfr_req.wr && (sfr_req.addr == wdg_pkg::SERVICE_ADDR);
  wire wr_control = sfr_req.wr && (sfr_req.addr == wdg_pkg::CONTROL_ADDR);
  wire rd_control = sfr_req.rd && (sfr_req.addr == wdg_pkg::CONTROL_ADDR);
  wire first_ok   = wr_service && (sfr_req.wdata == wdg_pkg::KEY_FIRST);
  wire second_ok  = wr_service && (sfr_req.wdata == wdg_pkg::KEY_SECOND);

  // armed: any write but the second key is a wrong sequence
  wire armed      = (key_q == wdg_pkg::WDG_KEY_ARMED);
  wire key_good   = armed && second_ok;
  wire key_bad    = (armed && sfr_req.wr && !second_ok)
                  || (!armed && wr_service && !first_ok);

  // power-down stops counting; idle stops it only when frozen
  wire count_en   = running_status_q && !power_down
                  && !(idle_mode && idle_freeze_q);
  wire tick       = &(pre_q | ~tap_mask(ps_q));
  wire timeout    = count_en && tick && (&tmr_q);

  wire fire       = timeout || key_bad;
  wire ovf_clear  = wr_control && !sfr_req.wdata[wdg_pkg::OVF_BIT];

  always_comb begin
    key_d = key_q;
    case (key_q)
      wdg_pkg::WDG_KEY_IDLE:  if (first_ok) key_d = wdg_pkg::WDG_KEY_ARMED;
      wdg_pkg::WDG_KEY_ARMED: if (sfr_req.wr) key_d = wdg_pkg::WDG_KEY_IDLE;
      default:                key_d = wdg_pkg::WDG_KEY_IDLE;
    endcase
  end

  wire [7:0] control_view = {ps_q, idle_freeze_q, 2'b00,
                             overflow_flag_q, running_status_q};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_q <= wdg_pkg::WDG_KEY_IDLE;
    end else if (other_reset) begin
      key_q <= wdg_pkg::WDG_KEY_IDLE;
    end else begin
      key_q <= key_d;
    end
  end

  // prescale and idle-freeze bits are cleared only by resetn; other_reset leaves them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ps_q          <= wdg_pkg::CONTROL_RESET[wdg_pkg::PS_MSB:wdg_pkg::PS_LSB];
      idle_freeze_q <= wdg_pkg::CONTROL_RESET[wdg_pkg::IDLE_BIT];
    end else if (wr_control && !armed) begin
      ps_q          <= sfr_req.wdata[wdg_pkg::PS_MSB:wdg_pkg::PS_LSB];
      idle_freeze_q <= sfr_req.wdata[wdg_pkg::IDLE_BIT];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflow_flag_q <= wdg_pkg::CONTROL_RESET[wdg_pkg::OVF_BIT];
    end else if (fire) begin
      overflow_flag_q <= 1'b1;
    end else if (ovf_clear) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // running bit changes only by key, timeout or reset; control writes skip it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running_status_q <= wdg_pkg::CONTROL_RESET[wdg_pkg::RUN_BIT];
    end else if (other_reset || fire) begin
      running_status_q <= 1'b0;
    end else if (key_good) begin
      running_status_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= wdg_pkg::PRE_ZERO;
      tmr_q <= wdg_pkg::TMR_ZERO;
    end else if (other_reset || fire || key_good) begin
      pre_q <= wdg_pkg::PRE_ZERO;
      tmr_q <= wdg_pkg::TMR_ZERO;
    end else if (count_en) begin
      pre_q <= pre_q + wdg_pkg::PRE_ONE;
      if (tick) begin
        tmr_q <= tmr_q + wdg_pkg::TMR_ONE;
      end
    end
  end

  // the service register never reads back; unmapped reads give zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata      <= wdg_pkg::READ_NONE;
      wd_reset_pulse <= 1'b0;
    end else begin
      sfr_rdata      <= rd_control ? control_view
                                   : wdg_pkg::READ_NONE;
      wd_reset_pulse <= fire;
    end
  end
endmodule // wdg_top
`default_nettype wire

// >>> testbench/wdg_cpu_model.sv
// cpu model issuing register accesses to the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdg_cpu_model (
  output var  wdg_pkg::wdg_sfr_req_t req = '0,
  input  wire logic                  clk
);
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge clk) req = '{w, !w, a, d};
    @(negedge clk) req = '{1'b0, 1'b0, ~a, ~d}; // released lines go inverse
  endtask
endmodule // wdg_cpu_model
`default_nettype wire

// >>> testbench/wdg_top_chk.sv
// port assertions for the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdg_top_chk (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  power_down,
  input wire wdg_pkg::wdg_sfr_req_t sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  wd_reset_pulse
);
  // only keys wrong in every state, so no key state is tracked here
  wire wrong = sfr_req.wr && sfr_req.addr == 8'hA6 &&
    !(sfr_req.wdata inside {8'h1E, 8'hE1});
  wire pd_hold = power_down && !sfr_req.wr;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // the partner spaces requests one idle cycle apart, hence the ##2 steps
  sequence key1_s;
    sfr_req.wr && sfr_req.addr == 8'hA6 && sfr_req.wdata == 8'h1E;
  endsequence
  sequence key2_s;
    sfr_req.wr && sfr_req.addr == 8'hA6 && sfr_req.wdata == 8'hE1;
  endsequence
  sequence ctl_wr_s;
    sfr_req.wr && sfr_req.addr == 8'hA7;
  endsequence
  key_between_a: assert property (key1_s ##2 ctl_wr_s |=> wd_reset_pulse)
    else $error("write between keys gave no reset pulse");
  good_feed_a: assert property (key1_s ##2 key2_s |=> !wd_reset_pulse)
    else $error("correct key pair gave a reset pulse");
  svc_read_a: assert property (sfr_req.rd && sfr_req.addr == 8'hA6
                               |=> sfr_rdata == 8'h00)
    else $error("service register read back non-zero");
  pulse_once_a: assert property (wd_reset_pulse |=> !wd_reset_pulse)
    else $error("reset pulse longer than one cycle");
  bad_key_a: assert property (wrong |=> wd_reset_pulse)
    else $error("wrong key gave no reset pulse");
  read_none_a: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero without a read");
  frozen_a: assert property (pd_hold |=> !wd_reset_pulse)
    else $error("reset pulse during power-down");
endmodule // wdg_top_chk
`default_nettype wire

// >>> testbench/programmable_watchdog_timer_bench.sv
// self-checking bench for the watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module programmable_watchdog_timer_bench;
  logic                  clk = 0, resetn = 0, other_reset = 0;
  logic                  idle_mode = 0, power_down = 0, wd_reset_pulse;
  logic [7:0]            sfr_rdata;
  wdg_pkg::wdg_sfr_req_t sfr_req;
  int                    n_mismatch = 0, n_tests = 0, n_pulse = 0;
  always #25 clk = ~clk;
  // counted mid-cycle so the registered pulse is settled when looked at
  always @(negedge clk) n_pulse += wd_reset_pulse;
  wdg_top dut (
    .clk            (clk),
    .resetn         (resetn),
    .other_reset    (other_reset),
    .idle_mode      (idle_mode),
    .power_down     (power_down),
    .sfr_req        (sfr_req),
    .sfr_rdata      (sfr_rdata),
    .wd_reset_pulse (wd_reset_pulse)
  );
  wdg_cpu_model cpu (.clk(clk), .req(sfr_req));
  task automatic r(input logic [7:0] a, e);
    cpu.acc(1'b0, a, 8'h00);
    `CHK(sfr_rdata, e)
  endtask
  task automatic end_of_test(input int late);
    n_mismatch += late;
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial #4ms end_of_test(1);
  initial begin
    #100 resetn = 1;
    cpu.acc(1'b1, 8'hA6, 8'h1E);
    cpu.acc(1'b1, 8'hA6, 8'hE1);
    r(8'hA7, 8'h01);
    power_down = 1;
    repeat (17000) @(negedge clk);
    power_down = 0;
    repeat (12000) @(negedge clk);
    cpu.acc(1'b1, 8'hA6, 8'h1E);
    cpu.acc(1'b1, 8'hA6, 8'hE1);
    repeat (16370) @(negedge clk);
    `CHK(n_pulse, 0)
    repeat (30) @(negedge clk);
    `CHK(n_pulse, 1)
    r(8'hA6, 8'h00);
    cpu.acc(1'b1, 8'hA6, 8'h1E);
    cpu.acc(1'b1, 8'hA7, 8'h10);
    cpu.acc(1'b1, 8'hA6, 8'h55);
    r(8'hA7, 8'h02);
    `CHK(n_pulse, 3)
    cpu.acc(1'b1, 8'hA7, 8'h12);
    r(8'hA7, 8'h12);
    cpu.acc(1'b1, 8'hA7, 8'h11);
    r(8'hA7, 8'h10);
    cpu.acc(1'b1, 8'hA6, 8'h1E);
    cpu.acc(1'b1, 8'hA6, 8'hE1);
    idle_mode = 1;
    repeat (17000) @(negedge clk);
    idle_mode = 0;
    `CHK(n_pulse, 3)
    @(negedge clk) other_reset = 1;
    @(negedge clk) other_reset = 0;
    r(8'hA7, 8'h10);
    end_of_test(0);
  end
endmodule // programmable_watchdog_timer_bench
bind wdg_top wdg_top_chk chk (
  .clk            (clk),
  .resetn         (resetn),
  .power_down     (power_down),
  .sfr_req        (sfr_req),
  .sfr_rdata      (sfr_rdata),
  .wd_reset_pulse (wd_reset_pulse)
);
`default_nettype wire
